// ==== hdl/asrc_pkg.sv ====
// package of constants for the standby and data-ready control block
package asrc_pkg;
    localparam int          CLK_HZ           = 50_000_000;
    localparam int          SETTLE_PERIODS   = 3;
    localparam int          READY_PULSE_CLKS = 500;
    localparam logic [31:0] RATE_DIV_RST     = 32'h000F_4240;
    localparam int          CNT_W            = 32;
    localparam logic [15:0] DATA_RST         = 16'h0000;
    localparam logic [31:0] MCLK_1M_HZ       = 32'h000F_4240;
    localparam logic [31:0] MCLK_2M4575_HZ   = 32'h0025_7F7C;
    localparam logic [7:0]  GAIN_BOOST_MAX   = 8'h04;
endpackage : asrc_pkg

// ==== hdl/asrc_boost.sv ====
// current boost selection from operating conditions
`timescale 1ns/10ps
`default_nettype none
module asrc_boost (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [31:0] mclk_hz_i,
    input  wire logic [7:0]  gain_i,
    output logic             boost_o
);
    typedef struct packed {
        logic boost;
    } asrc_boost_state_type;

    asrc_boost_state_type st_r;
    asrc_boost_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.boost = 1'b1;
        if (mclk_hz_i == asrc_pkg::MCLK_1M_HZ) begin
            st_nxt.boost = 1'b0;
        end else if (mclk_hz_i == asrc_pkg::MCLK_2M4575_HZ &&
                     gain_i <= asrc_pkg::GAIN_BOOST_MAX) begin
            st_nxt.boost = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign boost_o = st_r.boost;

    property p_boost_off_1m;
        @(posedge clk_i) disable iff (!reset_n_i)
        (mclk_hz_i == asrc_pkg::MCLK_1M_HZ) |=> !boost_o;
    endproperty
    a_boost_off_1m: assert property (p_boost_off_1m) else $error("boost on at 1 MHz");
endmodule : asrc_boost
`default_nettype wire

// ==== hdl/asrc_standby_ctrl.sv ====
// standby control and data-ready sequencing for the converter core
`timescale 1ns/10ps
`default_nettype none
module asrc_standby_ctrl #(
    parameter logic [31:0] RATE_DIV = asrc_pkg::RATE_DIV_RST,
    parameter int          PULSE    = asrc_pkg::READY_PULSE_CLKS
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        power_down_bit_i,
    input  wire logic        result_valid_i,
    input  wire logic [15:0] result_i,
    input  wire logic        read_done_i,
    input  wire logic [31:0] mclk_hz_i,
    input  wire logic [7:0]  gain_i,
    output logic             data_ready_n_o,
    output logic [15:0]      data_o,
    output logic             converting_o,
    output logic             mclk_run_o,
    output logic             boost_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_RUN, ST_DOWN, ST_SETTLE} asrc_mode_type;

    typedef struct packed {
        asrc_mode_type              mode;
        logic [asrc_pkg::CNT_W-1:0] cnt;
        logic [1:0]                 per;
        logic [15:0]                pulse;
        logic                       ready_n;
        logic [15:0]                data;
        logic                       run;
        logic                       clk_run;
    } asrc_state_type;

    asrc_state_type st_r;
    asrc_state_type st_nxt;
    logic           load;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        load   = 1'b0;
        unique case (st_r.mode)
            ST_RUN: begin
                if (power_down_bit_i) begin
                    st_nxt.mode = ST_DOWN;
                end else if (result_valid_i) begin
                    load = 1'b1;
                end
            end
            ST_DOWN: begin
                // everything held; only a read of the pending word acts
                if (!power_down_bit_i) begin
                    st_nxt.mode = ST_SETTLE;
                    st_nxt.cnt  = '0;
                    st_nxt.per  = '0;
                end
            end
            ST_SETTLE: begin
                if (power_down_bit_i) begin
                    st_nxt.mode = ST_DOWN;
                end else if (st_r.cnt == RATE_DIV - 32'h1) begin
                    st_nxt.cnt = '0;
                    if (st_r.per == 2'(asrc_pkg::SETTLE_PERIODS - 1)) begin
                        load        = 1'b1;
                        st_nxt.mode = ST_RUN;
                    end else begin
                        st_nxt.per = st_r.per + 2'h1;
                    end
                end else begin
                    st_nxt.cnt = st_r.cnt + 32'h1;
                end
            end
        endcase
        // pulse freezes in power-down so only a read moves the ready line in standby
        if (st_r.pulse != 16'h0000 && st_r.mode != ST_DOWN) begin
            st_nxt.pulse = st_r.pulse - 16'h0001;
            if (st_r.pulse == 16'h0001) begin
                st_nxt.ready_n = 1'b0;
            end
        end
        if (read_done_i) begin
            st_nxt.ready_n = 1'b1;
        end
        // load comes last so a same-cycle read loses to a new word
        if (load) begin
            st_nxt.data = result_i;
            if (!st_r.ready_n) begin
                st_nxt.ready_n = 1'b1;
                st_nxt.pulse   = 16'(PULSE);
            end else begin
                st_nxt.ready_n = 1'b0;
                st_nxt.pulse   = '0;
            end
        end
        // outputs registered from the next state, no decode after the flops
        st_nxt.run     = (st_nxt.mode == ST_RUN);
        st_nxt.clk_run = 1'b1; // oscillator is never gated by standby
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r.mode    <= ST_RUN;
            st_r.cnt     <= '0;
            st_r.per     <= '0;
            st_r.pulse   <= '0;
            st_r.ready_n <= 1'b1;
            st_r.data    <= asrc_pkg::DATA_RST;
            st_r.run     <= 1'b1;
            st_r.clk_run <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign data_ready_n_o = st_r.ready_n;
    assign data_o         = st_r.data;
    assign converting_o   = st_r.run;
    assign mclk_run_o     = st_r.clk_run;

    asrc_boost u_boost (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .mclk_hz_i (mclk_hz_i),
        .gain_i    (gain_i),
        .boost_o   (boost_o)
    );

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_hold_data;
        @(posedge clk_i) disable iff (!reset_n_i)
        (st_r.mode == ST_DOWN) |=> $stable(data_o);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("data changed in power-down");

    property p_no_result_down;
        @(posedge clk_i) disable iff (!reset_n_i)
        (st_r.mode == ST_DOWN && !read_done_i) |=> $stable(data_ready_n_o);
    endproperty
    a_no_result_down: assert property (p_no_result_down) else $error("ready moved in power-down");

    property p_enter_keeps;
        @(posedge clk_i) disable iff (!reset_n_i)
        (st_r.mode == ST_RUN && power_down_bit_i && !read_done_i && st_r.pulse == 16'h0000)
        |=> $stable(data_ready_n_o);
    endproperty
    a_enter_keeps: assert property (p_enter_keeps) else $error("entry moved ready");

    property p_read_sets;
        @(posedge clk_i) disable iff (!reset_n_i)
        (read_done_i && !load) |=> data_ready_n_o;
    endproperty
    a_read_sets: assert property (p_read_sets) else $error("read did not raise ready");

    property p_settle_load;
        @(posedge clk_i) disable iff (!reset_n_i)
        (st_r.mode == ST_SETTLE && !power_down_bit_i && st_r.cnt == RATE_DIV - 32'h1 &&
         st_r.per == 2'(asrc_pkg::SETTLE_PERIODS - 1))
        |=> (converting_o && data_o == $past(result_i));
    endproperty
    a_settle_load: assert property (p_settle_load) else $error("settle end lost");

    property p_pulse_high;
        @(posedge clk_i) disable iff (!reset_n_i)
        (load && !st_r.ready_n) |=> data_ready_n_o;
    endproperty
    a_pulse_high: assert property (p_pulse_high) else $error("update did not raise ready");

    property p_high_load_low;
        @(posedge clk_i) disable iff (!reset_n_i)
        (load && st_r.ready_n && !read_done_i) |=> !data_ready_n_o;
    endproperty
    a_high_load_low: assert property (p_high_load_low) else $error("new word not flagged");

    property p_mclk;
        @(posedge clk_i) disable iff (!reset_n_i)
        power_down_bit_i |-> mclk_run_o;
    endproperty
    a_mclk: assert property (p_mclk) else $error("clock stopped");

    // no early word while the settle count still runs
    property p_settle_quiet;
        @(posedge clk_i) disable iff (!reset_n_i)
        (st_r.mode == ST_SETTLE &&
         !(st_r.cnt == RATE_DIV - 32'h1 && st_r.per == 2'(asrc_pkg::SETTLE_PERIODS - 1)))
        |=> $stable(data_o);
    endproperty
    a_settle_quiet: assert property (p_settle_quiet) else $error("word before settle end");

    property p_down_idle;
        @(posedge clk_i) disable iff (!reset_n_i)
        (st_r.mode == ST_DOWN) |=> !converting_o;
    endproperty
    a_down_idle: assert property (p_down_idle) else $error("converting in power-down");

    property p_pulse_hold;
        @(posedge clk_i) disable iff (!reset_n_i)
        (st_r.pulse > 16'h0001 && !load) |=> data_ready_n_o;
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) else $error("ready pulse cut short");

    property p_pulse_end;
        @(posedge clk_i) disable iff (!reset_n_i)
        (st_r.pulse == 16'h0001 && st_r.mode != ST_DOWN && !read_done_i && !load)
        |=> !data_ready_n_o;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("ready not low after pulse");
endmodule : asrc_standby_ctrl
`default_nettype wire

// ==== tb/asrc_host_model.sv ====
// host model: ends data register reads on request
`timescale 1ns/10ps
`default_nettype none
module asrc_host_model (
    input  wire logic clk_i,
    input  wire logic rd_req_i,
    output var  logic read_done_o
);
    // one-cycle read end pulse, allowed in standby too; nba avoids an edge race
    always @(posedge clk_i) begin
        read_done_o <= rd_req_i;
    end
endmodule : asrc_host_model
`default_nettype wire

// ==== tb/tb_adc_standby_ready_control.sv ====
// testbench for the standby and data-ready control block
`timescale 1ns/10ps
`default_nettype none
module tb_adc_standby_ready_control;
    localparam logic [31:0] RD = 32'h0000_0004;
    localparam int          PL = 8;
    logic        clk_i, reset_n_i, power_down_bit_i, result_valid_i, rd_req, read_done_i;
    logic        data_ready_n_o, converting_o, mclk_run_o, boost_o;
    logic [15:0] result_i, data_o;
    logic [31:0] mclk_hz_i;
    logic [7:0]  gain_i;
    int          failures = 0;
    int          compares = 0;
    int          k;
    asrc_standby_ctrl #(.RATE_DIV(RD), .PULSE(PL)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .power_down_bit_i(power_down_bit_i), .result_valid_i(result_valid_i), .result_i(result_i),
        .read_done_i(read_done_i), .mclk_hz_i(mclk_hz_i), .gain_i(gain_i),
        .data_ready_n_o(data_ready_n_o), .data_o(data_o), .converting_o(converting_o),
        .mclk_run_o(mclk_run_o), .boost_o(boost_o));
    asrc_host_model i_host (.clk_i(clk_i), .rd_req_i(rd_req), .read_done_o(read_done_i));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_sim;
        if (failures == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task automatic load(input logic [15:0] v);
        result_valid_i = 1'b1;
        result_i = v;
        cyc(1);
        result_valid_i = 1'b0;
        cyc(2);
    endtask : load
    task automatic rd;
        rd_req = 1'b1;
        cyc(1);
        rd_req = 1'b0;
        cyc(3);
    endtask : rd
    // bounded wait; valid is dropped once the level shows so only one word loads
    task automatic wait_rdy(input logic lvl);
        k = 0;
        while (data_ready_n_o !== lvl && k < 40) begin
            cyc(1);
            k++;
        end
        result_valid_i = 1'b0;
        if (k == 40) begin
            chk("ready wait", 0, 1);
            end_sim();
        end
    endtask : wait_rdy
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_run;
        load(16'hA5C3);
        chk("ready", data_ready_n_o, 0);
        chk("data", data_o, 16'hA5C3);
        rd();
        chk("ready", data_ready_n_o, 1);
    endtask : t_run
    task automatic t_standby;
        load(16'h1234);
        power_down_bit_i = 1'b1;
        cyc(2);
        chk("converting", converting_o, 0);
        chk("ready", data_ready_n_o, 0);
        load(16'hFFFF);
        chk("data", data_o, 16'h1234);
        chk("mclk run", mclk_run_o, 1);
        rd();
        chk("ready", data_ready_n_o, 1);
        chk("data", data_o, 16'h1234);
    endtask : t_standby
    task automatic t_rel_high;
        power_down_bit_i = 1'b0;
        result_valid_i = 1'b1;
        result_i = 16'h0F0F;
        wait_rdy(1'b0);
        chk("settle", k, asrc_pkg::SETTLE_PERIODS * RD + 1);
        chk("data", data_o, 16'h0F0F);
        chk("converting", converting_o, 1);
    endtask : t_rel_high
    task automatic t_rel_low;
        power_down_bit_i = 1'b1;
        cyc(3);
        chk("ready", data_ready_n_o, 0);
        power_down_bit_i = 1'b0;
        result_valid_i = 1'b1;
        result_i = 16'h3C3C;
        wait_rdy(1'b1);
        chk("settle", k, asrc_pkg::SETTLE_PERIODS * RD + 1);
        chk("data", data_o, 16'h3C3C);
        wait_rdy(1'b0);
        chk("pulse", k, PL);
    endtask : t_rel_low
    // gain 1 to 5 at the 2.4575 MHz clock covers both sides of the boost limit
    task automatic t_boost;
        mclk_hz_i = asrc_pkg::MCLK_1M_HZ;
        gain_i = 8'h80;
        cyc(2);
        chk("boost", boost_o, 0);
        mclk_hz_i = asrc_pkg::MCLK_2M4575_HZ;
        for (int g = 1; g <= 5; g++) begin
            gain_i = 8'(g);
            cyc(2);
            chk("boost", boost_o, 32'(g > 4));
        end
        mclk_hz_i = 32'h004B_0000;
        gain_i = 8'h01;
        cyc(2);
        chk("boost", boost_o, 1);
    endtask : t_boost
    // ----------------------------------------
    // clock, reset and sequence
    // ----------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        reset_n_i = 1'b0;
        power_down_bit_i = 1'b0;
        result_valid_i = 1'b0;
        rd_req = 1'b0;
        result_i = 16'h0000;
        mclk_hz_i = asrc_pkg::MCLK_1M_HZ;
        gain_i = 8'h01;
        cyc(5);
        reset_n_i = 1'b1;
        cyc(2);
        t_run();
        t_standby();
        t_rel_high();
        t_rel_low();
        t_boost();
        end_sim();
    end
endmodule : tb_adc_standby_ready_control
`default_nettype wire
